// [motor_err_map.vh]
// motor_err_map.vh: constants for the motor stage error supervisor
// assumes inclusion by bare name from the design files
`ifndef MOTOR_ERR_MAP_VH
`define MOTOR_ERR_MAP_VH

// diagnostic word bit positions
`define DIAG_OVERLOAD_BIT 9
`define DIAG_OVERVOLT_BIT 11
`define DIAG_SHORT_BIT 12
`define DIAG_NOCTRL_BIT 14
`define DIAG_MISC_BIT 15
`define DIAG_OVERTEMP_BIT 8
// status byte bit positions
`define STAT_WARN_BIT 5
`define STAT_ERROR_BIT 6
// thresholds in percent of rated voltage
`define PCT_FULL 100
`define CHOP_THRESH_PCT 110
`define OVERVOLT_THRESH_PCT 110
// chopper duty: maximum on-time share in percent
`define CHOP_DUTY_MAX_PCT 50
// chopper pulse period in ns and in cycles at 25 MHz (40 ns)
`define CLK_PERIOD_NS 40
`define CHOP_PERIOD_NS 40000
`define CHOP_PERIOD_CYC (`CHOP_PERIOD_NS / `CLK_PERIOD_NS)
// reset values
`define DIAG_RESET 16'h0000

`endif

// [chopper_channel.v]
// chopper_channel.v: one output channel, motor drive or brake-resistor chopper
// assumes supply voltage and rated voltage share one unit and scale
`timescale 1ns/1ps
`include "motor_err_map.vh"

module chopper_channel #(
    parameter VW = 12,
    parameter PERIOD = `CHOP_PERIOD_CYC
) (
    input wire mclk,
    input wire rst,
    input wire ce,
    input wire chopperMode,
    input wire powerOn,
    input wire motorDrive,
    input wire [VW-1:0] supplyVolt,
    input wire [VW-1:0] ratedVolt,
    output reg stageOut_r,
    output reg chopActive_r
);

localparam CW = 16;
localparam [CW-1:0] PER = PERIOD[CW-1:0];
// on-time never exceeds half the period; integer division rounds down
localparam integer ONMAX_I = PERIOD * `CHOP_DUTY_MAX_PCT / `PCT_FULL;
localparam [CW-1:0] ONMAX = ONMAX_I[CW-1:0];
localparam [VW+7:0] FULL_PCT = `PCT_FULL;
localparam [VW+7:0] CHOP_PCT = `CHOP_THRESH_PCT;

reg [CW-1:0] cnt_r;
wire [VW+7:0] supplyScaled = {8'h00, supplyVolt} * FULL_PCT;
wire [VW+7:0] threshScaled = {8'h00, ratedVolt} * CHOP_PCT;
wire overThresh = (supplyScaled >= threshScaled);

always @(posedge mclk) begin
    if (rst) begin
        cnt_r <= 16'h0000;
        stageOut_r <= 1'b0;
        chopActive_r <= 1'b0;
    end else if (ce) begin
        cnt_r <= (cnt_r >= PER - 16'h0001) ? 16'h0000 : cnt_r + 16'h0001;
        chopActive_r <= chopperMode & overThresh & powerOn;
        if (!powerOn) begin
            stageOut_r <= 1'b0;
        end else if (chopperMode) begin // R9
            stageOut_r <= overThresh & (cnt_r < ONMAX); // R10 R11
        end else begin
            stageOut_r <= motorDrive;
        end
    end
end

endmodule // chopper_channel

// [motor_stage_error_handling.v]
// motor_stage_error_handling.v: error supervisor and two output channels
// assumes cause inputs are raw pins; ack and configuration come from same-clock logic
// assumes rst is high for at least one edge; reset acts whether or not ce is high
// Function
// R1: any hardware error removes motor power and sets the status error flag
// R2: short circuit sets its diagnostic bit and is a hardware error
// R3: control supply under minimum sets no-control-power bit, a hardware error
// R4: after control supply returns, device reinitializes itself without acknowledge
// R5: severe overtemperature sets misc error and overtemperature warning, a hardware error
// R6: inconsistent configuration at initialization sets misc error, a hardware error
// R7: overload escalates to misc error only when configured, with overload warning
// R8: partner clears cause then acknowledges; device then cancels error indication
// R9: each channel can be configured into brake-resistor chopper mode
// R10: in chopper mode, supply at threshold of rated voltage drives pulses
// R11: chopper pulse duty never exceeds its maximum
// R12: motor voltage above rated plus margin sets warning and overvoltage bit
// R13: error bits latch until acknowledged; ack with live cause keeps error
`timescale 1ns/1ps
`include "motor_err_map.vh"

module motor_stage_error_handling #(
    parameter VW = 12,
    parameter CHOP_PERIOD = `CHOP_PERIOD_CYC
) (
    input wire mclk,
    input wire rst,
    input wire ce,
    input wire shortCircuit,
    input wire ctrlPowerLow,
    input wire overTemp,
    input wire severeOverTemp,
    input wire overload,
    input wire configInvalid,
    input wire overload_as_error_cfg,
    input wire error_acknowledge_bit,
    input wire [1:0] chopper_mode_select,
    input wire [1:0] motorDrive,
    input wire [VW-1:0] supplyVolt,
    input wire [VW-1:0] rated_voltage_setting,
    output wire [15:0] diagWord,
    output wire [7:0] statusByte,
    output wire status_error_flag,
    output wire [1:0] stageOut,
    output wire [1:0] chopActive,
    output reg initBusy_r
);

////////////////////////////////////////////////////////////////////////////////
// synchronise pin causes
// bit order: short, control low, overtemp, severe heat, overload
// limitation: a cause pulse shorter than one clock may be missed
reg [4:0] sync1_r;
reg [4:0] sync2_r;
always @(posedge mclk) begin
    if (rst) begin
        sync1_r <= 5'h00;
        sync2_r <= 5'h00;
    end else if (ce) begin
        sync1_r <= {shortCircuit, ctrlPowerLow, overTemp, severeOverTemp, overload};
        sync2_r <= sync1_r;
    end
end
wire shortS = sync2_r[4];
wire ctrlLowS = sync2_r[3];
wire overTempS = sync2_r[2];
wire severeS = sync2_r[1];
wire overloadS = sync2_r[0];

////////////////////////////////////////////////////////////////////////////////
// initialization: one check cycle after reset or after control power returns
reg ctrlLowPrev_r;
reg initReq_r;
always @(posedge mclk) begin
    if (rst) begin
        ctrlLowPrev_r <= 1'b0;
        initReq_r <= 1'b1;
        initBusy_r <= 1'b1;
    end else if (ce) begin
        ctrlLowPrev_r <= ctrlLowS;
        // falling edge of low-supply restarts init with no acknowledge
        initReq_r <= ctrlLowPrev_r & ~ctrlLowS; // R4
        // previous level bridges the edge between supply return and the check cycle
        initBusy_r <= initReq_r | ctrlLowS | ctrlLowPrev_r;
    end
end
wire initCheck = initReq_r;

////////////////////////////////////////////////////////////////////////////////
// diagnostic bit registers; all latch except the overtemperature warning
reg shortLat_r;
reg noCtrlLat_r;
reg miscLat_r;
reg overloadLat_r;
reg overvoltLat_r;
reg otempLat_r;

// percent factors at the width of the scaled words
localparam [VW+7:0] FULL_PCT = `PCT_FULL;
localparam [VW+7:0] OV_PCT = `OVERVOLT_THRESH_PCT;

wire ovl = overloadS & overload_as_error_cfg; // R7
// configuration is judged only in the single check cycle of an init
wire cfgBad = initCheck & configInvalid; // R6
wire miscCause = severeS | ovl | cfgBad; // R5 R7
// ack cancels only bits whose cause is gone; set wins over clear
wire ackClr = error_acknowledge_bit;
// both sides scaled to percent, so no divider is needed
wire [VW+7:0] supScaled = {8'h00, supplyVolt} * FULL_PCT;
wire [VW+7:0] ovThresh = {8'h00, rated_voltage_setting} * OV_PCT;
wire overvoltNow = supScaled > ovThresh; // R12

// short circuit: held until an ack comes after the pin has gone quiet
always @(posedge mclk) begin
    if (rst) begin
        shortLat_r <= 1'b0;
    end else if (ce) begin
        shortLat_r <= shortS | (shortLat_r & ~ackClr); // R2 R13
    end
end

// control power: cleared by the init check cycle, no ack needed
always @(posedge mclk) begin
    if (rst) begin
        noCtrlLat_r <= 1'b0;
    end else if (ce) begin
        noCtrlLat_r <= ctrlLowS | (noCtrlLat_r & ~initReq_r); // R3 R4
    end
end

// misc error: severe heat, bad configuration or escalated overload
always @(posedge mclk) begin
    if (rst) begin
        miscLat_r <= 1'b0;
    end else if (ce) begin
        miscLat_r <= miscCause | (miscLat_r & ~ackClr); // R13 R8
    end
end

// overload warning latches whether or not it escalates
always @(posedge mclk) begin
    if (rst) begin
        overloadLat_r <= 1'b0;
    end else if (ce) begin
        overloadLat_r <= overloadS | (overloadLat_r & ~ackClr); // R7
    end
end

// overvoltage warning stays until acknowledged
always @(posedge mclk) begin
    if (rst) begin
        overvoltLat_r <= 1'b0;
    end else if (ce) begin
        overvoltLat_r <= overvoltNow | (overvoltLat_r & ~ackClr); // R12
    end
end

// overtemperature warning follows its cause; severe heat forces it too
always @(posedge mclk) begin
    if (rst) begin
        otempLat_r <= 1'b0;
    end else if (ce) begin
        otempLat_r <= overTempS | severeS; // R5
    end
end

wire hwError = shortLat_r | noCtrlLat_r | miscLat_r; // R1
wire warnAny = overloadLat_r | overvoltLat_r | otempLat_r; // R12

////////////////////////////////////////////////////////////////////////////////
// output assembly
// registered so status byte and diagnostic word change on the same edge
// unused diagnostic and status bits read as zero
reg [15:0] diag_r;
reg [7:0] stat_r;
always @(posedge mclk) begin
    if (rst) begin
        diag_r <= `DIAG_RESET;
        stat_r <= 8'h00;
    end else if (ce) begin
        diag_r <= `DIAG_RESET;
        diag_r[`DIAG_SHORT_BIT] <= shortLat_r;
        diag_r[`DIAG_NOCTRL_BIT] <= noCtrlLat_r;
        diag_r[`DIAG_MISC_BIT] <= miscLat_r;
        diag_r[`DIAG_OVERLOAD_BIT] <= overloadLat_r;
        diag_r[`DIAG_OVERVOLT_BIT] <= overvoltLat_r;
        diag_r[`DIAG_OVERTEMP_BIT] <= otempLat_r;
        stat_r <= 8'h00;
        stat_r[`STAT_ERROR_BIT] <= hwError; // R1
        stat_r[`STAT_WARN_BIT] <= warnAny; // R12
    end
end
assign diagWord = diag_r;
assign statusByte = stat_r;
assign status_error_flag = stat_r[`STAT_ERROR_BIT];

// power stays off while any error is latched or init runs
wire powerOn = ~hwError & ~initBusy_r; // R1 R13

////////////////////////////////////////////////////////////////////////////////
// channels
// one instance per channel; both share the power gate, each has its own counter
genvar g;
generate
    for (g = 0; g < 2; g = g + 1) begin : ch
        chopper_channel #(
            .VW(VW),
            .PERIOD(CHOP_PERIOD)
        ) u_chan (
            .mclk(mclk),
            .rst(rst),
            .ce(ce),
            .chopperMode(chopper_mode_select[g]),
            .powerOn(powerOn),
            .motorDrive(motorDrive[g]),
            .supplyVolt(supplyVolt),
            .ratedVolt(rated_voltage_setting),
            .stageOut_r(stageOut[g]),
            .chopActive_r(chopActive[g])
        );
    end
endgenerate

endmodule // motor_stage_error_handling

// [motor_stage_chk_sva.sv]
// checker: port relations of the motor stage error supervisor
// assumes nothing is judged while ce is low; bound to the top module by port name
`timescale 1ns/1ps
module motor_stage_chk (
    input wire mclk,
    input wire rst,
    input wire ce,
    input wire shortCircuit,
    input wire ctrlPowerLow,
    input wire severeOverTemp,
    input wire overload,
    input wire overload_as_error_cfg,
    input wire error_acknowledge_bit,
    input wire [15:0] diagWord,
    input wire status_error_flag,
    input wire [1:0] stageOut,
    input wire [1:0] chopActive
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst || !ce);
    ////////////////////////////////////////
    property p_off; status_error_flag |-> stageOut == 2'h0; endproperty
    a_off: assert property (p_off) else $error("stage driven during error");
    property p_flag; |{diagWord[15:14], diagWord[12]} |-> status_error_flag; endproperty
    a_flag: assert property (p_flag) else $error("error bit without flag");
    property p_short; $rose(shortCircuit) |-> ##[2:5] diagWord[12]; endproperty
    a_short: assert property (p_short) else $error("short not latched");
    property p_ctrl; $rose(ctrlPowerLow) |-> ##[2:5] diagWord[14]; endproperty
    a_ctrl: assert property (p_ctrl) else $error("control power loss missed");
    property p_reinit; $fell(ctrlPowerLow) |-> ##[2:10] !diagWord[14]; endproperty
    a_reinit: assert property (p_reinit) else $error("no automatic recovery");
    property p_hot; $rose(severeOverTemp) |-> ##[2:5] diagWord[15] && diagWord[8]; endproperty
    a_hot: assert property (p_hot) else $error("severe heat missed");
    property p_ovl;
        $rose(overload) && overload_as_error_cfg |-> ##[2:5] diagWord[15] && diagWord[9];
    endproperty
    a_ovl: assert property (p_ovl) else $error("overload not escalated");
    property p_hold; !error_acknowledge_bit[*2] ##0 diagWord[12] |=> diagWord[12]; endproperty
    a_hold: assert property (p_hold) else $error("short bit lost");
    c_err: cover property ($rose(status_error_flag));
    c_clr: cover property ($fell(status_error_flag));
    c_chop: cover property (chopActive[0]);
endmodule // motor_stage_chk
bind motor_stage_error_handling motor_stage_chk chk (.*);

// [bus_coupler_model.sv]
// partner: bus coupler that acknowledges errors and warnings
// assumes the bench tells it when the cause has been cleared
`timescale 1ns/1ps
module bus_coupler_model (
    input wire mclk,
    input wire rst,
    input wire [7:0] statusByte,
    input wire causeGone,
    output reg error_acknowledge_bit = 1'b0
);
    // held while anything is flagged; an early ack only if the bench claims so
    always @(posedge mclk) begin
        error_acknowledge_bit <= #2 !rst && causeGone && |statusByte[6:5];
    end
endmodule // bus_coupler_model

// [tb_motor_stage_error_handling.sv]
// testbench: error and chopper scenarios for the motor stage supervisor
// assumes a short chopper period of 10 cycles
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin mismatches++; \
    $display("[ERR] %0t mismatch %h", $time, a); end end
module tb_motor_stage_error_handling;
    logic mclk = 0, rst = 1, ce = 1, shortCircuit = 0, ctrlPowerLow = 0, overTemp = 0;
    logic severeOverTemp = 0, overload = 0, configInvalid = 0, overload_as_error_cfg = 0;
    logic causeGone = 0, error_acknowledge_bit, status_error_flag, initBusy_r;
    logic [1:0] chopper_mode_select = 0, motorDrive = 2'h3, stageOut, chopActive;
    logic [11:0] supplyVolt = 12'h064, rated_voltage_setting = 12'h064;
    logic [15:0] diagWord;
    logic [7:0] statusByte;
    int mismatches = 0, samples_checked = 0, n;
    motor_stage_error_handling #(.CHOP_PERIOD(10)) DUT (.*);
    bus_coupler_model partner (.*);
    initial begin
        forever #20 mclk = ~mclk;
    end
    ////////////////////////////////////////
    task tick(input int k);
        repeat (k) @(posedge mclk);
        #2;
    endtask
    task clearErr;
        causeGone = 1;
        n = 0;
        while (statusByte[6:5] !== 2'h0 && n < 50) begin
            tick(1);
            n++;
        end
        causeGone = 0;
        if (statusByte[6:5] !== 2'h0) begin
            mismatches++;
            $display("[ERR] %0t error not cleared", $time);
            results;
        end else begin
            tick(2);
            `CHK(diagWord, 16'h0)
        end
    endtask
    task tFreeze;
        ce = 0;
        shortCircuit = 1;
        tick(6);
        `CHK({diagWord[12], status_error_flag, stageOut}, 4'h3)
        shortCircuit = 0;
        ce = 1;
        tick(4);
        `CHK({diagWord[12], status_error_flag, stageOut}, 4'h3)
    endtask
    task doReset(input logic bad);
        rst = 1;
        configInvalid = bad;
        tick(4);
        rst = 0;
        tick(3);
        configInvalid = 0;
        `CHK(diagWord, {bad, 15'h0})
        `CHK({statusByte, stageOut, initBusy_r}, {1'b0, bad, 6'h0, ~{bad, bad}, 1'b0})
    endtask
    task tShort;
        shortCircuit = 1;
        tick(5);
        `CHK({diagWord[12], status_error_flag, stageOut}, 4'hc)
        causeGone = 1;
        tick(6);
        `CHK({diagWord[12], status_error_flag, stageOut}, 4'hc)
        shortCircuit = 0;
        clearErr;
        `CHK(stageOut, 2'h3)
    endtask
    task tCtrl;
        ctrlPowerLow = 1;
        tick(5);
        `CHK({diagWord[14], status_error_flag, stageOut}, 4'hc)
        ctrlPowerLow = 0;
        tick(10);
        `CHK({diagWord, status_error_flag}, 17'h0)
        `CHK({stageOut, initBusy_r}, 3'h6)
    endtask
    task tHot;
        severeOverTemp = 1;
        overTemp = 1;
        tick(5);
        `CHK({diagWord[15], diagWord[8], status_error_flag}, 3'h7)
        severeOverTemp = 0;
        overTemp = 0;
        clearErr;
    endtask
    task tOvl(input logic cfg);
        overload_as_error_cfg = cfg;
        overload = 1;
        tick(5);
        `CHK({diagWord[15], diagWord[9], statusByte[6:5]}, {cfg, 1'b1, cfg, 1'b1})
        overload = 0;
        clearErr;
    endtask
    task tChop;
        chopper_mode_select = 2'h1;
        motorDrive = 2'h2;
        supplyVolt = 12'h06e;
        tick(3);
        n = 0;
        // two whole periods; floor(10/2) on-cycles in each
        repeat (20) begin
            tick(1);
            n += (stageOut[0] === 1'b1);
        end
        `CHK(n, 10)
        `CHK({chopActive, stageOut[1], diagWord[11]}, 4'h6)
        supplyVolt = 12'h06f;
        tick(5);
        `CHK({diagWord[11], statusByte[5]}, 2'h3)
        supplyVolt = 12'h06d;
        tick(3);
        `CHK({chopActive, stageOut[0]}, 3'h0)
        clearErr;
        chopper_mode_select = 2'h0;
        motorDrive = 2'h3;
    endtask
    task results;
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        doReset(0);
        doReset(1);
        clearErr;
        tShort;
        tCtrl;
        tFreeze;
        tHot;
        tOvl(0);
        tOvl(1);
        tChop;
        results;
    end
endmodule // tb_motor_stage_error_handling
